// >>> lpd_led_load.sv
// Load model for the two density outputs: counts lit cycles.
// Assumes the outputs are sampled on core_clk rising edges.
`timescale 1ns/1ns
module lpd_led_load (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Density inputs
  input wire logic density_out_a,
  input wire logic density_out_b,
  // Lit cycle counts
  output logic [15:0] on_a,
  output logic [15:0] on_b
);
  // The load draws current only while its input is high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      on_a <= 16'h0;
      on_b <= 16'h0;
    end else begin
      on_a <= on_a + 16'(density_out_a);
      on_b <= on_b + 16'(density_out_b);
    end
  end
endmodule

// >>> lpd_modulator.sv
// Contract
// RULE_01 - Advance sequence each clock while enabled
// RULE_02 - Software loads a nonzero seed
// RULE_03 - Reset input reloads start value; code reloads only while run_ok, so a clear control enable blocks it
// RULE_04 - Kill forces both density outputs low
// RULE_05 - Serial output shows state LSB
// RULE_06 - Both outputs share one random sequence
// RULE_07 - Compare less-or-equal, alternatively greater-or-equal
// RULE_08 - Width configurable from 2 to 32
// RULE_09 - Run-enable bit gates all generation
// RULE_10 - Two independent compare-mode bits
// RULE_11 - Fixed-compare option drops control register
// RULE_12 - Working seed register, software read/write
// RULE_13 - Shadow seed copied in on reset
// RULE_14 - Software updates shadow with new seed
// RULE_15 - Polynomial register holds feedback taps
// RULE_16 - Two density threshold registers
// RULE_17 - Galois right shift, XOR taps on one
// RULE_18 - Mode zero LE, one GE; registered outputs
//
// Holds the density update FIFO and the modulator top with its APB slave.
// Assumes APB master on core_clk; enable, reset and kill arrive as async pins.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ns

module lpd_fifo
  import lpd_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = LPD_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_sync_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } lpd_fifo_s;

  lpd_fifo_s st;
  lpd_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  // Full and empty from the occupancy count
  // One extra count bit tells a full buffer from an empty one
  // without the wasted slot of pointer-only schemes
  assign in_ready = (st.count != (PW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data = mem[st.rd_ptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointer and count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = (st.wr_ptr == PW'(DEPTH - 1)) ? '0 : st.wr_ptr + PW'(1);
    end
    if (pop) begin
      next_st.rd_ptr = (st.rd_ptr == PW'(DEPTH - 1)) ? '0 : st.rd_ptr + PW'(1);
    end
    // Simultaneous push and pop leave the count alone
    case ({push, pop})
      2'h2: next_st.count = st.count + (PW+1)'(1);
      2'h1: next_st.count = st.count - (PW+1)'(1);
      default: next_st.count = st.count;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage, no reset needed
  // Words are only read behind a nonzero count, so stale data never escapes
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[st.wr_ptr] <= in_data;
    end
  end

endmodule

module lpd_modulator
  import lpd_pkg::*;
#(
  parameter int unsigned SEQ_W = LPD_WIDTH_DEFAULT,
  parameter bit FIXED_COMPARE = 1'b0,
  parameter bit FIXED_MODE_A = 1'b0,
  parameter bit FIXED_MODE_B = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous control pins
  input wire logic run_enable_in,
  input wire logic seq_reset_in,
  input wire logic kill_in,
  // Modulated outputs
  output logic density_out_a,
  output logic density_out_b,
  output logic bitstream_out
);

  // Width kept inside the supported range [RULE_08]
  // Out-of-range widths are clamped rather than refused
  localparam int unsigned W = (SEQ_W < LPD_WIDTH_MIN) ? LPD_WIDTH_MIN :
                              (SEQ_W > LPD_WIDTH_MAX) ? LPD_WIDTH_MAX : SEQ_W;
  localparam int unsigned FW = W + 1;
  localparam int unsigned PIN_EN = 0;
  localparam int unsigned PIN_RST = 1;
  localparam int unsigned PIN_KILL = 2;

  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic ctrl_en;
    logic mode_a;
    logic mode_b;
    logic [W-1:0] seed;
    logic [W-1:0] seed_copy;
    logic [W-1:0] poly;
    logic [W-1:0] thr_a;
    logic [W-1:0] thr_b;
    logic [31:0] rdata;
    logic out_a;
    logic out_b;
  } lpd_state_s;

  localparam lpd_state_s ST_RESET = '{
    pin_s1: 3'h0,
    pin_s2: 3'h0,
    ctrl_en: LPD_CTRL_EN_RESET,
    mode_a: LPD_MODE_A_RESET,
    mode_b: LPD_MODE_B_RESET,
    seed: LPD_SEED_RESET[W-1:0],
    seed_copy: LPD_SEED_RESET[W-1:0],
    poly: LPD_POLY_RESET[W-1:0],
    thr_a: LPD_DENS_RESET[W-1:0],
    thr_b: LPD_DENS_RESET[W-1:0],
    rdata: 32'h0000_0000,
    out_a: 1'b0,
    out_b: 1'b0
  };

  lpd_state_s st;
  lpd_state_s next_st;
  logic [1:0] rst_sync;
  logic rst_sync_b;

  // Decoded bus and pin terms
  logic setup;
  logic access;
  logic dens_hit;
  logic wr_take;
  logic run_ok;
  logic en_s;
  logic seq_rst_s;
  logic kill_s;
  logic running;
  logic mode_a_eff;
  logic mode_b_eff;
  logic [W-1:0] lfsr_step;

  // Density update buffer ports
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [FW-1:0] fifo_in_data;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [FW-1:0] fifo_out_data;

  // Density comparator, mode zero is LE, one is GE [RULE_07] [RULE_18]
  function automatic logic density_cmp(input logic [W-1:0] rnd, input logic [W-1:0] thr,
                                       input logic mode);
    density_cmp = (mode == LPD_MODE_GE) ? (rnd >= thr) : (rnd <= thr);
  endfunction

  // True for every offset the slave answers
  function automatic logic reg_mapped(input logic [7:0] addr);
    reg_mapped = (addr == LPD_OFF_CTRL) || (addr == LPD_OFF_SEED) ||
                 (addr == LPD_OFF_SEED_COPY) || (addr == LPD_OFF_POLY) ||
                 (addr == LPD_OFF_DENS_A) || (addr == LPD_OFF_DENS_B);
  endfunction

  // Zero-extend a sequence-width value onto the bus
  function automatic logic [31:0] widen(input logic [W-1:0] val);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[W-1:0] = val;
    widen = r;
  endfunction

  // Reset release through two flops
  // Assertion is immediate; release waits two edges so that every flop
  // on rst_sync_b leaves reset on the same clock edge
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_sync[1];

  // Pin levels after the second sync flop only
  // The first flop may go metastable, so nothing but the second reads it
  // Each pin therefore lags its pad by two clock edges
  assign en_s = st.pin_s2[PIN_EN];
  assign seq_rst_s = st.pin_s2[PIN_RST];
  assign kill_s = st.pin_s2[PIN_KILL];

  // Run gate; control register absent in fixed-compare builds [RULE_09] [RULE_11]
  assign run_ok = FIXED_COMPARE ? 1'b1 : st.ctrl_en;
  assign mode_a_eff = FIXED_COMPARE ? FIXED_MODE_A : st.mode_a; // [RULE_10] [RULE_11]
  assign mode_b_eff = FIXED_COMPARE ? FIXED_MODE_B : st.mode_b; // [RULE_10] [RULE_11]
  assign running = run_ok & en_s & ~seq_rst_s;

  // Galois step: shift right, fold taps in when a one falls out [RULE_17] [RULE_15]
  // An all-zero state locks up, so software must seed nonzero
  assign lfsr_step = (st.seed >> 1) ^ (st.seed[0] ? st.poly : '0);

  // APB phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign dens_hit = (paddr == LPD_OFF_DENS_A) || (paddr == LPD_OFF_DENS_B);

  // Density writes queue; a full buffer stretches the access phase
  // Only threshold writes can stall; reads and other writes never wait
  assign fifo_in_valid = access & pwrite & dens_hit;
  assign fifo_in_data = {(paddr == LPD_OFF_DENS_B), pwdata[W-1:0]};
  assign pready = ~fifo_in_valid | fifo_in_ready;
  assign pslverr = access & ~reg_mapped(paddr);
  assign wr_take = access & pwrite & pready & reg_mapped(paddr);
  assign prdata = st.rdata;

  // Thresholds change only at the sequence start point while running
  // A threshold change mid-period would skew that period's density,
  // so updates wait for the seed to pass its start value again
  assign fifo_out_ready = ~running | (st.seed == st.seed_copy);

  lpd_fifo #(
    .WIDTH(FW),
    .DEPTH(LPD_FIFO_DEPTH)
  ) u_dens_fifo (
    .core_clk(core_clk),
    .rst_sync_b(rst_sync_b),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;

    // Pin synchronisers
    next_st.pin_s1 = {kill_in, seq_reset_in, run_enable_in};
    next_st.pin_s2 = st.pin_s1;

    // Sequence: reload on reset input, else step while enabled [RULE_01] [RULE_03] [RULE_13]
    // Reload needs run_ok (control enable set); with it clear the pin is ignored, even with run_enable_in high
    if (run_ok && seq_rst_s) begin
      next_st.seed = st.seed_copy;
    end else if (running) begin
      next_st.seed = lfsr_step;
    end

    // Register writes; a software seed write wins over the step [RULE_12] [RULE_14]
    // A seed write leaves the shadow alone; software writes both
    if (wr_take) begin
      case (paddr)
        LPD_OFF_CTRL: begin
          if (!FIXED_COMPARE) begin
            next_st.ctrl_en = pwdata[LPD_CTRL_EN_BIT]; // [RULE_09]
            next_st.mode_a = pwdata[LPD_CTRL_MODE_A_BIT]; // [RULE_10]
            next_st.mode_b = pwdata[LPD_CTRL_MODE_B_BIT]; // [RULE_10]
          end
        end
        LPD_OFF_SEED: next_st.seed = pwdata[W-1:0]; // [RULE_12]
        LPD_OFF_SEED_COPY: next_st.seed_copy = pwdata[W-1:0]; // [RULE_13]
        LPD_OFF_POLY: next_st.poly = pwdata[W-1:0]; // [RULE_15]
        default: begin
        end
      endcase
    end

    // Drain one queued threshold update [RULE_16]
    // One entry per start point while running, so a burst takes periods
    if (fifo_out_valid && fifo_out_ready) begin
      if (fifo_out_data[W]) begin
        next_st.thr_b = fifo_out_data[W-1:0];
      end else begin
        next_st.thr_a = fifo_out_data[W-1:0];
      end
    end

    // Read data captured in the setup cycle
    // Keeps prdata a flop output and lets reads finish
    // with no wait state
    if (setup && !pwrite) begin
      case (paddr)
        LPD_OFF_CTRL: begin
          next_st.rdata = 32'h0000_0000;
          if (!FIXED_COMPARE) begin
            next_st.rdata[LPD_CTRL_EN_BIT] = st.ctrl_en;
            next_st.rdata[LPD_CTRL_MODE_A_BIT] = st.mode_a;
            next_st.rdata[LPD_CTRL_MODE_B_BIT] = st.mode_b;
          end
        end
        LPD_OFF_SEED: next_st.rdata = widen(st.seed); // [RULE_12]
        LPD_OFF_SEED_COPY: next_st.rdata = widen(st.seed_copy);
        LPD_OFF_POLY: next_st.rdata = widen(st.poly);
        LPD_OFF_DENS_A: next_st.rdata = widen(st.thr_a);
        LPD_OFF_DENS_B: next_st.rdata = widen(st.thr_b);
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end

    // Registered density outputs from the one shared sequence [RULE_06] [RULE_18]
    // Kill and a clear control enable force both outputs low,
    // with no combinational path from the pins to the outputs
    next_st.out_a = run_ok & ~kill_s & density_cmp(st.seed, st.thr_a, mode_a_eff); // [RULE_04]
    next_st.out_b = run_ok & ~kill_s & density_cmp(st.seed, st.thr_b, mode_b_eff); // [RULE_04]
  end

  // State register
  // Block state apart from rst_sync and the density buffer lives in one struct register
  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Output drive
  // The serial output follows the seed even while stopped
  assign density_out_a = st.out_a;
  assign density_out_b = st.out_b;
  assign bitstream_out = st.seed[0]; // [RULE_05]

endmodule

// >>> lpd_modulator_props.sv
// Port-level assertions for the density modulator.
// Assumes it is bound to lpd_modulator and sees only its ports.
`timescale 1ns/1ns
module lpd_modulator_props #(
  parameter int unsigned SEQ_W = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Pins
  input wire logic run_enable_in,
  input wire logic seq_reset_in,
  input wire logic kill_in,
  input wire logic density_out_a,
  input wire logic density_out_b,
  input wire logic bitstream_out
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  logic bad;
  // Access phase and unmapped decode
  assign acc = psel && penable;
  assign bad = paddr > 8'h14 || paddr[1:0] != 2'h0;
  AST_ERR_UNMAPPED: assert property (acc && bad |-> pslverr) else $error("no error on unmapped");
  AST_ERR_MAPPED: assert property (acc && !bad |-> !pslverr) else $error("error on mapped");
  AST_READ_NOWAIT: assert property (acc && !pwrite |-> pready) else $error("read stalled");
  AST_WRITE_NOWAIT: assert property (acc && pwrite && paddr < 8'h10 |-> pready) else $error("write stalled");
  AST_KILL_LOW: assert property (kill_in [*4] |-> !density_out_a && !density_out_b)
    else $error("output high under kill");
  AST_STOP_HOLD: assert property ((!run_enable_in && !seq_reset_in && !(psel && pwrite)) [*5]
    |-> $stable(bitstream_out)) else $error("sequence moved while stopped");
  AST_RELOAD_HOLD: assert property ((seq_reset_in && !(psel && pwrite)) [*5]
    |-> $stable(bitstream_out)) else $error("sequence moved under reload");
  AST_RESET_STATE: assert property ($rose(rst_b) |-> bitstream_out && !density_out_a && !density_out_b)
    else $error("bad outputs after reset");
  // Main scenarios
  cover property (acc && bad);
  cover property (acc && !pready);
  cover property (kill_in && density_out_a);
endmodule
bind lpd_modulator lpd_modulator_props #(.SEQ_W(SEQ_W)) lpd_modulator_props_inst (.core_clk(core_clk),
  .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .run_enable_in(run_enable_in), .seq_reset_in(seq_reset_in), .kill_in(kill_in),
  .density_out_a(density_out_a), .density_out_b(density_out_b), .bitstream_out(bitstream_out));

// >>> lpd_pkg.sv
// Shared constants for the pseudo-random pulse density modulator.
// Assumes a 32-bit APB register bus with byte addresses, one word per register.
package lpd_pkg;

  // Register byte offsets
  localparam logic [7:0] LPD_OFF_CTRL = 8'h00;
  localparam logic [7:0] LPD_OFF_SEED = 8'h04;
  localparam logic [7:0] LPD_OFF_SEED_COPY = 8'h08;
  localparam logic [7:0] LPD_OFF_POLY = 8'h0C;
  localparam logic [7:0] LPD_OFF_DENS_A = 8'h10;
  localparam logic [7:0] LPD_OFF_DENS_B = 8'h14;

  // Control register field positions
  localparam int unsigned LPD_CTRL_EN_BIT = 0;
  localparam int unsigned LPD_CTRL_MODE_A_BIT = 1;
  localparam int unsigned LPD_CTRL_MODE_B_BIT = 2;

  // Compare mode encodings
  localparam logic LPD_MODE_LE = 1'b0;
  localparam logic LPD_MODE_GE = 1'b1;

  // Reset values, cut to the sequence width where used
  localparam logic LPD_CTRL_EN_RESET = 1'b0;
  localparam logic LPD_MODE_A_RESET = 1'b0;
  localparam logic LPD_MODE_B_RESET = 1'b0;
  localparam logic [31:0] LPD_SEED_RESET = 32'h0000_0001;
  localparam logic [31:0] LPD_POLY_RESET = 32'h0000_00B8;
  localparam logic [31:0] LPD_DENS_RESET = 32'h0000_0000;

  // Sequence width limits and default
  localparam int unsigned LPD_WIDTH_MIN = 2;
  localparam int unsigned LPD_WIDTH_MAX = 32;
  localparam int unsigned LPD_WIDTH_DEFAULT = 8;

  // Density update buffer depth
  localparam int unsigned LPD_FIFO_DEPTH = 16;

endpackage

// >>> testbench.sv
// Self-checking bench for the density modulator.
// Assumes lpd_pkg, the modulator and lpd_led_load are compiled first.
`timescale 1ns/1ns
module testbench;
  import lpd_pkg::*;
  localparam int unsigned W = 8;
  logic core_clk, rst_b, psel, penable, pwrite, run_enable_in, seq_reset_in, kill_in;
  logic pready, pslverr, serr, found, density_out_a, density_out_b, bitstream_out;
  logic density_out_a_f, density_out_b_f, bitstream_out_f;
  logic [7:0] paddr, s, da, db;
  logic [2:0] m;
  logic [31:0] pwdata, prdata, prdata_f, rd, g, rnd;
  logic [15:0] on_a, on_b, snap;
  int n_errors, tests_run, waits, maxw;
  // Clock
  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;
  lpd_modulator #(.SEQ_W(W)) lpd_modulator_inst (.core_clk(core_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .run_enable_in(run_enable_in), .seq_reset_in(seq_reset_in), .kill_in(kill_in),
    .density_out_a(density_out_a), .density_out_b(density_out_b), .bitstream_out(bitstream_out));
  lpd_led_load lpd_led_load_inst (.core_clk(core_clk), .rst_b(rst_b), .density_out_a(density_out_a),
    .density_out_b(density_out_b), .on_a(on_a), .on_b(on_b));
  // Fixed-compare build at a narrow width on the same bus and pins
  lpd_modulator #(.SEQ_W(4), .FIXED_COMPARE(1'b1), .FIXED_MODE_A(1'b1), .FIXED_MODE_B(1'b0)) lpd_modulator_fixed_inst (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_f), .pready(), .pslverr(), .run_enable_in(run_enable_in),
    .seq_reset_in(seq_reset_in), .kill_in(kill_in), .density_out_a(density_out_a_f),
    .density_out_b(density_out_b_f), .bitstream_out(bitstream_out_f));
  // Random source
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h8020_0003 : 32'h0);
  endfunction
  // One sequence step with the reset taps
  function automatic logic [7:0] step(input logic [7:0] v);
    return {1'b0, v[7:1]} ^ (v[0] ? LPD_POLY_RESET[7:0] : 8'h00);
  endfunction
  // Expected comparator level
  function automatic logic dens(input logic en, ge, k, input logic [7:0] v, d);
    return en && !k && (ge ? v >= d : v <= d);
  endfunction
  task automatic chk_val(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    waits = 0;
    do begin
      @(posedge core_clk);
      waits++;
    end while (pready !== 1'b1 && waits < 1000);
    if (pready !== 1'b1) begin
      n_errors++;
      end_sim();
    end
    rd = prdata;
    serr = pslverr;
    if (waits > maxw) maxw = waits;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, run_enable_in, seq_reset_in, kill_in} = '0;
    n_errors = 0;
    tests_run = 0;
    maxw = 0;
    rnd = 32'hF913EE45;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk_val(rd, (i == 1 || i == 2) ? 32'h1 : (i == 3 ? 32'hB8 : 32'h0));
    end
    apb(1'b0, 8'h18, 32'h0);
    chk_bit(serr, 1'b1);
    // Random modes, seeds, thresholds and kill, sequence stopped
    repeat (24) begin
      rnd = lfsr(rnd);
      m = rnd[2:0];
      s = rnd[10:3] == 8'h00 ? 8'h01 : rnd[10:3];
      da = rnd[31] ? s : rnd[18:11];
      db = rnd[30] ? s : rnd[26:19];
      apb(1'b1, LPD_OFF_CTRL, {29'h0, m});
      apb(1'b1, LPD_OFF_SEED, {24'h0, s});
      apb(1'b1, LPD_OFF_SEED_COPY, {24'h0, s});
      apb(1'b1, LPD_OFF_DENS_A, {24'h0, da});
      apb(1'b1, LPD_OFF_DENS_B, {24'h0, db});
      kill_in <= rnd[29];
      repeat (6) @(posedge core_clk);
      chk_bit(density_out_a, dens(m[0], m[1], rnd[29], s, da));
      chk_bit(density_out_b, dens(m[0], m[2], rnd[29], s, db));
      chk_bit(bitstream_out, s[0]);
      chk_bit(density_out_a_f, dens(1'b1, 1'b1, rnd[29], {4'h0, s[3:0]}, {4'h0, da[3:0]}));
      chk_bit(density_out_b_f, dens(1'b1, 1'b0, rnd[29], {4'h0, s[3:0]}, {4'h0, db[3:0]}));
      chk_bit(bitstream_out_f, s[0]);
      apb(1'b0, LPD_OFF_CTRL, 32'h0);
      chk_val(rd, {29'h0, m});
      chk_val(prdata_f, 32'h0);
    end
    // Kill seen by the load with an always-lit setting
    apb(1'b1, LPD_OFF_CTRL, 32'h1);
    apb(1'b1, LPD_OFF_DENS_A, 32'hFF);
    kill_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    snap = on_a;
    repeat (8) @(posedge core_clk);
    chk_val({16'h0, on_a}, {16'h0, snap});
    kill_in <= 1'b0;
    repeat (4) @(posedge core_clk);
    snap = on_a;
    repeat (8) @(posedge core_clk);
    chk_val({16'h0, on_a}, {16'h0, snap + 16'h8});
    // Run about forty steps, then hold
    apb(1'b1, LPD_OFF_SEED, 32'h5A);
    apb(1'b1, LPD_OFF_SEED_COPY, 32'h5A);
    run_enable_in <= 1'b1;
    repeat (40) @(posedge core_clk);
    run_enable_in <= 1'b0;
    repeat (6) @(posedge core_clk);
    apb(1'b0, LPD_OFF_SEED, 32'h0);
    g = rd;
    s = 8'h5A;
    found = 1'b0;
    for (int i = 1; i < 60; i++) begin
      s = step(s);
      if (s === g[7:0] && i == 40) found = 1'b1;
    end
    chk_bit(found, 1'b1);
    repeat (20) @(posedge core_clk);
    apb(1'b0, LPD_OFF_SEED, 32'h0);
    chk_val(rd, g);
    // Reload the start value
    seq_reset_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    seq_reset_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    apb(1'b0, LPD_OFF_SEED, 32'h0);
    chk_val(rd, 32'h5A);
    // Reload refused once the control enable is cleared
    run_enable_in <= 1'b1;
    repeat (10) @(posedge core_clk);
    apb(1'b1, LPD_OFF_CTRL, 32'h0);
    run_enable_in <= 1'b0;
    apb(1'b0, LPD_OFF_SEED, 32'h0);
    g = rd;
    chk_bit(g[7:0] !== 8'h5A, 1'b1);
    seq_reset_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    seq_reset_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    apb(1'b0, LPD_OFF_SEED, 32'h0);
    chk_val(rd, g);
    apb(1'b1, LPD_OFF_CTRL, 32'h1);
    // Overfill the threshold buffer while running
    apb(1'b1, LPD_OFF_SEED, 32'h1);
    apb(1'b1, LPD_OFF_SEED_COPY, 32'h1);
    run_enable_in <= 1'b1;
    maxw = 0;
    for (int i = 1; i <= 20; i++) apb(1'b1, LPD_OFF_DENS_A, 32'(i));
    run_enable_in <= 1'b0;
    repeat (30) @(posedge core_clk);
    apb(1'b0, LPD_OFF_DENS_A, 32'h0);
    chk_val(rd, 32'h14);
    chk_bit(maxw > 1, 1'b1);
    end_sim();
  end
endmodule
